// [logic/spds_pkg.sv]
// Contract
// - static mode drives one identical waveform on all four common outputs
// - 2-division uses commons 0-1, 3-division uses 0-2; others float
// - segment data comes from a 40-byte display memory FA58H..FA7FH
// - while common k is active, bit k of each segment byte is used; static mode uses bit 0 for all commons
// - bit 1 gives segment select voltage, bit 0 gives unselect voltage
// - segments 24..39 share pins with port functions; 0..23 are dedicated
// - memory bits above the active common count are ignored by the display
// - upper four bits of every display memory byte read as zero
// - only common select with segment select yields full drive difference
// - all waveforms alternate so no net DC appears across a pixel
// - static lit segment is the common waveform shifted one frame
// - static unlit segment follows the common waveform in phase
// - segment 0 maps to FA7FH, higher segments to descending addresses
// - mode value 10100100B selects static, 256 Hz scan rate, display on
// - control value 01000010B takes power from bias pin, segments 24-31 in use
// - setting the supply bit of the watch timer mode starts the scan clock
// - clock select 00000000B makes the watch timer count the main clock
// - static, 1/2 duty 1/2 bias, 1/3 duty both biases, 1/4 duty 1/3 bias
// - with display off every segment drives its unselect waveform
// - scan clock comes only from the watch timer; clearing supply stops it
package spds_pkg;
	localparam logic [15:0] SPDS_MEM_FIRST = 16'hFA58;
	localparam logic [15:0] SPDS_MEM_LAST = 16'hFA7F;
	localparam logic [15:0] SPDS_MODE_ADDR = 16'hFFB0;
	localparam logic [15:0] SPDS_CTRL_ADDR = 16'hFFB2;
	localparam logic [15:0] SPDS_WT_MODE_ADDR = 16'hFF41;
	localparam logic [15:0] SPDS_WT_CSEL_ADDR = 16'hFF42;
	localparam int SPDS_MEM_BYTES = 40;
	localparam int SPDS_COMS = 4;
	localparam int SPDS_DEDICATED_SEGS = 24;
	localparam int SPDS_SEGS_32 = 32;
	localparam int SPDS_SEGS_40 = 40;
	localparam logic [7:0] SPDS_MODE_RST = 8'h00;
	localparam logic [7:0] SPDS_CTRL_RST = 8'h00;
	localparam logic [7:0] SPDS_WT_MODE_RST = 8'h00;
	localparam logic [7:0] SPDS_WT_CSEL_RST = 8'h00;
	localparam logic [7:0] SPDS_MODE_WMASK = 8'hF7;
	localparam int SPDS_MODE_ON_BIT = 7;
	localparam int SPDS_MODE_RATE_LSB = 4;
	localparam int SPDS_MODE_DRV_LSB = 0;
	localparam int SPDS_CTRL_BIAS_BIT = 6;
	localparam int SPDS_CTRL_SEG_LSB = 0;
	localparam int SPDS_WT_SUPPLY_BIT = 1;
	localparam int SPDS_WT_SRC_LSB = 3;
	localparam logic [2:0] SPDS_SEG_USE_32 = 3'h2;
	localparam logic [2:0] SPDS_SEG_USE_40 = 3'h3;
	localparam logic [2:0] SPDS_RATE_MAX = 3'h3;
	localparam int SPDS_WT_MAIN_EXP = 7;
	localparam int SPDS_SCAN_MAX_EXP = 9;

	typedef enum logic [2:0] {
		SPDS_DRV_4_THIRD = 3'h0,
		SPDS_DRV_3_THIRD = 3'h1,
		SPDS_DRV_2_HALF = 3'h2,
		SPDS_DRV_3_HALF = 3'h3,
		SPDS_DRV_STATIC = 3'h4
	} spds_drive_t;

	typedef enum logic [1:0] {
		SPDS_PH_C0 = 2'h0,
		SPDS_PH_C1 = 2'h1,
		SPDS_PH_C2 = 2'h3,
		SPDS_PH_C3 = 2'h2
	} spds_phase_t;

	// drive level in sixths of the panel drive voltage
	typedef logic [2:0] spds_level_t;
	localparam spds_level_t SPDS_LVL_LOW = 3'h0;
	localparam spds_level_t SPDS_LVL_THIRD = 3'h2;
	localparam spds_level_t SPDS_LVL_HALF = 3'h3;
	localparam spds_level_t SPDS_LVL_TWO_THIRDS = 3'h4;
	localparam spds_level_t SPDS_LVL_FULL = 3'h6;
endpackage: spds_pkg

// [logic/spds_scan_if.sv]
`timescale 1ns/1ps
interface spds_scan_if;
	logic src_sub;
	logic supply_en;
	logic [2:0] rate_sel;
	logic scan_tick;
	modport ctrl(output src_sub, output supply_en, output rate_sel, input scan_tick);
	modport timer(input src_sub, input supply_en, input rate_sel, output scan_tick);
endinterface: spds_scan_if

// [logic/spds_scan_timer.sv]
`timescale 1ns/1ps
module spds_scan_timer
	import spds_pkg::*;
#(
	parameter int WT_MAIN_EXP = SPDS_WT_MAIN_EXP
) (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// subsystem clock pin
	input wire logic sub_clk_pin,
	// sequencer side
	spds_scan_if.timer scan
);
	logic sub_meta_reg;
	logic sub_sync_reg;
	logic sub_prev_reg;
	logic [WT_MAIN_EXP-1:0] main_div_reg;
	logic [SPDS_SCAN_MAX_EXP-1:0] prescale_reg;
	logic tick_reg;
	logic fw_tick;

	if (WT_MAIN_EXP < 1 || WT_MAIN_EXP > 16) begin : g_bad_exp
		$error("main prescale exponent out of range");
	end

	function automatic logic carry_f(logic [SPDS_SCAN_MAX_EXP-1:0] cnt, logic [2:0] rate);
		logic [3:0] ex;
		ex = 4'(SPDS_SCAN_MAX_EXP) - {1'b0, rate};
		carry_f = 1'b1;
		for (int i = 0; i < SPDS_SCAN_MAX_EXP; i++) begin
			if (4'(i) < ex && !cnt[i]) begin
				carry_f = 1'b0;
			end
		end
	endfunction: carry_f

	//--------------------------------
	// subsystem clock synchroniser
	//--------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sub_meta_reg <= 1'b0;
			sub_sync_reg <= 1'b0;
			sub_prev_reg <= 1'b0;
		end else if (ce) begin
			sub_meta_reg <= sub_clk_pin;
			sub_sync_reg <= sub_meta_reg;
			sub_prev_reg <= sub_sync_reg;
		end
	end

	// main clock prescaler runs while supply is on; its carry counts only when software selects it
	assign fw_tick = scan.src_sub ? (sub_sync_reg && !sub_prev_reg) : (&main_div_reg);

	//--------------------------------
	// watch timer prescaler
	//--------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			main_div_reg <= '0;
		end else if (ce) begin
			if (!scan.supply_en) begin
				main_div_reg <= '0;
			end else begin
				main_div_reg <= main_div_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prescale_reg <= '0;
			tick_reg <= 1'b0;
		end else if (ce) begin
			if (!scan.supply_en) begin
				prescale_reg <= '0;
				tick_reg <= 1'b0;
			end else begin
				if (fw_tick) begin
					prescale_reg <= prescale_reg + 1'b1;
				end
				tick_reg <= fw_tick && carry_f(prescale_reg, scan.rate_sel);
			end
		end
	end

	// gating by supply stops ticks at once, not a cycle late
	assign scan.scan_tick = tick_reg && scan.supply_en;

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_supply_stop;
		(ce && !scan.supply_en) |=> (prescale_reg == '0 && !scan.scan_tick);
	endproperty
	a_supply_stop: assert property (p_supply_stop) else $error("scan clock not stopped");
endmodule: spds_scan_timer

// [logic/spds_panel_sequencer.sv]
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module spds_panel_sequencer
	import spds_pkg::*;
#(
	parameter int SEG_COUNT = SPDS_MEM_BYTES
) (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// subsystem clock pin
	input wire logic sub_clk_pin,
	// panel drive
	output spds_level_t [SPDS_COMS-1:0] com_level,
	output logic [SPDS_COMS-1:0] com_oe,
	output spds_level_t [SEG_COUNT-1:0] seg_level,
	output logic [SEG_COUNT-1:0] seg_oe,
	output logic power_from_bias
);
	if (SEG_COUNT < SPDS_DEDICATED_SEGS || SEG_COUNT > SPDS_MEM_BYTES) begin : g_bad_segs
		$error("segment count out of range");
	end

	//--------------------------------
	// functions
	//--------------------------------
	function automatic spds_drive_t drive_f(logic [2:0] code);
		case (code)
			3'h0: drive_f = SPDS_DRV_4_THIRD;
			3'h1: drive_f = SPDS_DRV_3_THIRD;
			3'h2: drive_f = SPDS_DRV_2_HALF;
			3'h3: drive_f = SPDS_DRV_3_HALF;
			default: drive_f = SPDS_DRV_STATIC;
		endcase
	endfunction: drive_f

	function automatic logic [1:0] last_com_f(spds_drive_t d);
		case (d)
			SPDS_DRV_STATIC: last_com_f = 2'h0;
			SPDS_DRV_2_HALF: last_com_f = 2'h1;
			SPDS_DRV_3_HALF: last_com_f = 2'h2;
			SPDS_DRV_3_THIRD: last_com_f = 2'h2;
			default: last_com_f = 2'h3;
		endcase
	endfunction: last_com_f

	function automatic logic [1:0] phase_num_f(spds_phase_t ph);
		case (ph)
			SPDS_PH_C0: phase_num_f = 2'h0;
			SPDS_PH_C1: phase_num_f = 2'h1;
			SPDS_PH_C2: phase_num_f = 2'h2;
			SPDS_PH_C3: phase_num_f = 2'h3;
			default: phase_num_f = 2'h0;
		endcase
	endfunction: phase_num_f

	function automatic spds_level_t com_lvl_f(logic sel, logic pol, logic third);
		if (sel) begin
			com_lvl_f = pol ? SPDS_LVL_LOW : SPDS_LVL_FULL;
		end else if (third) begin
			com_lvl_f = pol ? SPDS_LVL_TWO_THIRDS : SPDS_LVL_THIRD;
		end else begin
			com_lvl_f = SPDS_LVL_HALF;
		end
	endfunction: com_lvl_f

	// select is the mirror of a selected common; unselect copies it, or
	// sits at the inner third level under 1/3 bias
	function automatic spds_level_t seg_lvl_f(logic on, logic pol, logic third);
		if (on) begin
			seg_lvl_f = pol ? SPDS_LVL_FULL : SPDS_LVL_LOW;
		end else if (third) begin
			seg_lvl_f = pol ? SPDS_LVL_THIRD : SPDS_LVL_TWO_THIRDS;
		end else begin
			seg_lvl_f = pol ? SPDS_LVL_LOW : SPDS_LVL_FULL;
		end
	endfunction: seg_lvl_f

	function automatic spds_level_t gap_f(spds_level_t a, spds_level_t b);
		gap_f = (a > b) ? a - b : b - a;
	endfunction: gap_f

	function automatic int seg_use_f(logic [2:0] sel);
		case (sel)
			SPDS_SEG_USE_32: seg_use_f = SPDS_SEGS_32;
			SPDS_SEG_USE_40: seg_use_f = SPDS_SEGS_40;
			default: seg_use_f = SPDS_DEDICATED_SEGS;
		endcase
	endfunction: seg_use_f

	//--------------------------------
	// registers
	//--------------------------------
	logic [7:0] display_mode_reg;
	logic [7:0] display_control_reg;
	logic [7:0] watch_timer_mode_reg;
	logic [7:0] watch_timer_clock_select;
	logic [3:0] mem [SPDS_MEM_BYTES];
	logic in_mem;
	logic [5:0] mem_idx;
	logic [15:0] mem_off;
	logic [7:0] rd_next;

	assign in_mem = reg_addr >= SPDS_MEM_FIRST && reg_addr <= SPDS_MEM_LAST;
	assign mem_off = reg_addr - SPDS_MEM_FIRST;
	assign mem_idx = mem_off[5:0];

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			display_mode_reg <= SPDS_MODE_RST;
			display_control_reg <= SPDS_CTRL_RST;
			watch_timer_mode_reg <= SPDS_WT_MODE_RST;
			watch_timer_clock_select <= SPDS_WT_CSEL_RST;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				SPDS_MODE_ADDR: display_mode_reg <= reg_wdata & SPDS_MODE_WMASK;
				SPDS_CTRL_ADDR: display_control_reg <= reg_wdata;
				SPDS_WT_MODE_ADDR: watch_timer_mode_reg <= reg_wdata;
				SPDS_WT_CSEL_ADDR: watch_timer_clock_select <= reg_wdata;
				default: ;
			endcase
		end
	end

	// no reset here: software fills the memory before turning on
	always_ff @(posedge core_clk) begin
		if (ce && reg_wr && in_mem) begin
			mem[mem_idx] <= reg_wdata[3:0];
		end
	end

	always_comb begin
		rd_next = 8'h00;
		if (in_mem) begin
			rd_next = {4'h0, mem[mem_idx]};
		end else begin
			case (reg_addr)
				SPDS_MODE_ADDR: rd_next = display_mode_reg;
				SPDS_CTRL_ADDR: rd_next = display_control_reg;
				SPDS_WT_MODE_ADDR: rd_next = watch_timer_mode_reg;
				SPDS_WT_CSEL_ADDR: rd_next = watch_timer_clock_select;
				default: rd_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			reg_rdata <= reg_rd ? rd_next : 8'h00;
		end
	end

	//--------------------------------
	// mode decode and scan clock
	//--------------------------------
	spds_drive_t drive;
	logic is_static;
	logic bias_third;
	logic disp_on;
	logic [1:0] last_num;
	logic [1:0] cur_num;
	logic [2:0] rate_raw;
	spds_phase_t phase_reg;
	logic pol_reg;
	spds_scan_if scan_bus();

	assign drive = drive_f(display_mode_reg[SPDS_MODE_DRV_LSB +: 3]);
	assign is_static = drive == SPDS_DRV_STATIC;
	assign bias_third = drive == SPDS_DRV_4_THIRD || drive == SPDS_DRV_3_THIRD;
	assign disp_on = display_mode_reg[SPDS_MODE_ON_BIT];
	assign last_num = last_com_f(drive);
	assign cur_num = phase_num_f(phase_reg);
	assign rate_raw = display_mode_reg[SPDS_MODE_RATE_LSB +: 3];
	// prohibited rate codes fall back to the fastest legal rate
	assign scan_bus.rate_sel = (rate_raw > SPDS_RATE_MAX) ? SPDS_RATE_MAX : rate_raw;
	assign scan_bus.supply_en = watch_timer_mode_reg[SPDS_WT_SUPPLY_BIT];
	assign scan_bus.src_sub = watch_timer_clock_select[SPDS_WT_SRC_LSB +: 2] != 2'h0;

	spds_scan_timer #(
		.WT_MAIN_EXP(SPDS_WT_MAIN_EXP)
	) u_timer (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.sub_clk_pin(sub_clk_pin),
		.scan(scan_bus)
	);

	//--------------------------------
	// common scan sequencer
	//--------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase_reg <= SPDS_PH_C0;
			pol_reg <= 1'b0;
		end else if (ce) begin
			if (cur_num > last_num) begin
				phase_reg <= SPDS_PH_C0;
			end else if (scan_bus.scan_tick) begin
				if (cur_num == last_num) begin
					phase_reg <= SPDS_PH_C0;
					pol_reg <= ~pol_reg;
				end else begin
					case (phase_reg)
						SPDS_PH_C0: phase_reg <= SPDS_PH_C1;
						SPDS_PH_C1: phase_reg <= SPDS_PH_C2;
						SPDS_PH_C2: phase_reg <= SPDS_PH_C3;
						default: phase_reg <= SPDS_PH_C0;
					endcase
				end
			end
		end
	end

	//--------------------------------
	// waveform levels
	//--------------------------------
	spds_level_t [SPDS_COMS-1:0] com_next;
	logic [SPDS_COMS-1:0] com_oe_next;
	spds_level_t [SEG_COUNT-1:0] seg_next;
	logic [SEG_COUNT-1:0] seg_oe_next;
	int seg_used;

	assign seg_used = seg_use_f(display_control_reg[SPDS_CTRL_SEG_LSB +: 3]);

	always_comb begin
		for (int k = 0; k < SPDS_COMS; k++) begin
			com_next[k] = com_lvl_f(is_static || 2'(k) == cur_num, pol_reg, bias_third);
			com_oe_next[k] = is_static || 2'(k) <= last_num;
		end
		for (int s = 0; s < SEG_COUNT; s++) begin
			// bit cur_num of the byte; higher bits never reach the pins
			seg_next[s] = seg_lvl_f(disp_on && mem[SPDS_MEM_BYTES-1-s][cur_num],
				pol_reg, bias_third);
			seg_oe_next[s] = s < SPDS_DEDICATED_SEGS || s < seg_used;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			com_level <= '0;
			com_oe <= '0;
			seg_level <= '0;
			seg_oe <= '0;
			power_from_bias <= 1'b0;
		end else if (ce) begin
			com_level <= com_next;
			com_oe <= com_oe_next;
			seg_level <= seg_next;
			seg_oe <= seg_oe_next;
			power_from_bias <= display_control_reg[SPDS_CTRL_BIAS_BIT];
		end
	end

	//--------------------------------
	// assertions
	//--------------------------------
	logic pix0_lit;
	spds_level_t seg0_dark;
	assign pix0_lit = disp_on && mem[SPDS_MEM_BYTES-1][cur_num] && (is_static || cur_num == 2'h0);
	assign seg0_dark = seg_lvl_f(1'b0, pol_reg, bias_third);

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_frame_end;
		ce && scan_bus.scan_tick && cur_num == last_num;
	endsequence
	sequence s_static_held;
		ce && is_static ##1 ce && is_static;
	endsequence

	property p_frame_flip;
		s_frame_end |=> pol_reg != $past(pol_reg) && phase_reg == SPDS_PH_C0;
	endproperty
	a_frame_flip: assert property (p_frame_flip) else $error("frame polarity not inverted");
	property p_static_same;
		ce && is_static |=> com_level[0] == com_level[1] && com_level[1] == com_level[2]
			&& com_level[2] == com_level[3] && com_oe == 4'hF;
	endproperty
	a_static_same: assert property (p_static_same) else $error("static commons differ");
	property p_div2_open;
		ce && drive == SPDS_DRV_2_HALF |=> com_oe == 4'h3;
	endproperty
	a_div2_open: assert property (p_div2_open) else $error("unused common driven");
	property p_nibble_zero;
		ce && reg_rd && in_mem |=> reg_rdata[7:4] == 4'h0;
	endproperty
	a_nibble_zero: assert property (p_nibble_zero) else $error("memory high nibble set");
	property p_blank;
		// rst in the antecedent keeps the release edge from starting an attempt
		ce && !rst && !disp_on |=> seg_level[0] == $past(seg0_dark);
	endproperty
	a_blank: assert property (p_blank) else $error("segment lit while off");
	property p_pixel;
		ce && !rst |=> (gap_f(com_level[0], seg_level[0]) == SPDS_LVL_FULL) == $past(pix0_lit);
	endproperty
	a_pixel: assert property (p_pixel) else $error("pixel drive mismatch");
	property p_static_lit;
		ce && is_static && pix0_lit |=> seg_level[0] == SPDS_LVL_FULL - com_level[0];
	endproperty
	a_static_lit: assert property (p_static_lit) else $error("lit segment not inverted");
	property p_static_dark;
		ce && is_static && !pix0_lit |=> seg_level[0] == com_level[0];
	endproperty
	a_static_dark: assert property (p_static_dark) else $error("dark segment off phase");
	property p_static_phase;
		s_static_held |-> phase_reg == SPDS_PH_C0;
	endproperty
	a_static_phase: assert property (p_static_phase) else $error("static left phase 0");
endmodule: spds_panel_sequencer

// [sim/spds_panel_model.sv]
`timescale 1ns/1ps
module spds_panel_model
	import spds_pkg::*;
#(
	parameter int SEG_COUNT = SPDS_MEM_BYTES
) (
	// drive from the sequencer
	input wire spds_level_t [SPDS_COMS-1:0] com_level,
	input wire logic [SPDS_COMS-1:0] com_oe,
	input wire spds_level_t [SEG_COUNT-1:0] seg_level,
	input wire logic [SEG_COUNT-1:0] seg_oe,
	// optical state of the glass
	output logic [SEG_COUNT-1:0][SPDS_COMS-1:0] lit,
	output logic stressed
);
	// ----------------------------------------
	// pixel response
	// ----------------------------------------
	// an open pin carries no charge, so only pixels driven on both plates count
	always_comb begin
		int d;
		d = 0;
		lit = '0;
		stressed = 1'b0;
		for (int s = 0; s < SEG_COUNT; s++) begin
			for (int k = 0; k < SPDS_COMS; k++) begin
				d = int'(com_level[k]) - int'(seg_level[s]);
				if (d < 0) begin
					d = -d;
				end
				if (com_oe[k] && seg_oe[s] && d == 6) begin
					lit[s][k] = 1'b1;
				end
				// partial difference would ghost the pixel
				if (com_oe[k] && seg_oe[s] && d > 3 && d < 6) begin
					stressed = 1'b1;
				end
			end
		end
	end
endmodule: spds_panel_model

// [sim/spds_panel_sequencer_bench.sv]
`timescale 1ns/1ps
module spds_panel_sequencer_bench
	import spds_pkg::*;
;
	localparam int SC = 40;
	typedef struct {
		logic [7:0] mode;
		logic [7:0] ctrl;
		logic [7:0] csel;
		int n;
		logic half;
		int segs;
		int period;
	} spds_row_t;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic core_clk, rst, ce, reg_wr, reg_rd, sub_clk_pin;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rd;
	spds_level_t [SPDS_COMS-1:0] com_level, prev_com;
	logic [SPDS_COMS-1:0] com_oe;
	spds_level_t [SC-1:0] seg_level;
	logic [SC-1:0] seg_oe;
	logic power_from_bias, stressed, pol, prev_pol, have_prev, stat, b;
	// set before time zero so the monitor stays idle on the first clock edge
	logic chk_on = 1'b0;
	logic [SC-1:0][SPDS_COMS-1:0] lit;
	logic [1:0] sub_div;
	logic [3:0] mem_nib [SC];
	spds_level_t unsel;
	spds_row_t cur;
	int errors = 0;
	int cmp_count = 0;
	int act, prev_act, n_chg, cyc, w;
	// sub clock rows run 256 core cycles per scan step at rate 3
	spds_row_t rows [0:8] = '{
		'{8'hB0, 8'h03, 8'h08, 4, 1'b0, 40, 256},
		'{8'hB1, 8'h02, 8'h08, 3, 1'b0, 32, 256},
		'{8'hB2, 8'h00, 8'h10, 2, 1'b1, 24, 256},
		'{8'hB3, 8'h43, 8'h18, 3, 1'b1, 40, 256},
		'{8'hA4, 8'h42, 8'h08, 1, 1'b1, 32, 512},
		'{8'hBD, 8'h01, 8'h08, 1, 1'b1, 24, 256},
		'{8'h30, 8'h03, 8'h08, 4, 1'b0, 40, 256},
		'{8'hF2, 8'h03, 8'h08, 2, 1'b1, 40, 256},
		'{8'hB2, 8'h03, 8'h00, 2, 1'b1, 40, 8192}
	};
	spds_panel_sequencer #(.SEG_COUNT(SC)) dut (.core_clk(core_clk), .rst(rst), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sub_clk_pin(sub_clk_pin), .com_level(com_level),
		.com_oe(com_oe), .seg_level(seg_level), .seg_oe(seg_oe),
		.power_from_bias(power_from_bias));
	spds_panel_model #(.SEG_COUNT(SC)) glass (.com_level(com_level), .com_oe(com_oe),
		.seg_level(seg_level), .seg_oe(seg_oe), .lit(lit), .stressed(stressed));
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		sub_div <= sub_div + 2'h1;
		sub_clk_pin <= sub_div[1];
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic tally(input logic ok, input string what);
		cmp_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask: tally
	task automatic check_lvl(input spds_level_t got, input spds_level_t exp);
		tally(got === exp, "drive level");
	endtask: check_lvl
	task automatic check_bit(input logic got, input logic exp);
		tally(got === exp, "flag");
	endtask: check_bit
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		tally(got === exp, "read data");
	endtask: check_byte
	task automatic check_mask(input logic [SC-1:0] got, input logic [SC-1:0] exp);
		tally(got === exp, "enable mask");
	endtask: check_mask
	task automatic check_cnt(input int got, input int exp);
		tally(got == exp, "count");
	endtask: check_cnt
	task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// one idle edge, so a following call never re-raises the strobe in this step
		@(posedge core_clk);
	endtask: reg_write
	task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
		@(posedge core_clk);
	endtask: reg_read
	function automatic spds_level_t seg_exp(input logic on, input logic p, input logic h);
		if (on) return p ? SPDS_LVL_FULL : SPDS_LVL_LOW;
		if (h) return p ? SPDS_LVL_LOW : SPDS_LVL_FULL;
		return p ? SPDS_LVL_THIRD : SPDS_LVL_TWO_THIRDS;
	endfunction: seg_exp
	task automatic wrap_up();
		if (errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask: wrap_up
	// ----------------------------------------
	// waveform monitor
	// ----------------------------------------
	always @(negedge core_clk) begin
		if (!chk_on) begin
			have_prev = 1'b0;
			n_chg = 0;
		end else begin
			stat = (cur.n == 1);
			act = 0;
			for (int k = 1; k < cur.n; k++) begin
				if (com_level[k] === SPDS_LVL_LOW || com_level[k] === SPDS_LVL_FULL) act = k;
			end
			pol = (com_level[act] === SPDS_LVL_LOW);
			unsel = cur.half ? SPDS_LVL_HALF : (pol ? SPDS_LVL_TWO_THIRDS : SPDS_LVL_THIRD);
			check_bit(pol || com_level[act] === SPDS_LVL_FULL, 1'b1);
			check_mask(SC'(com_oe), stat ? SC'(4'hF) : (SC'(1) << cur.n) - 1);
			check_bit(stressed, 1'b0);
			for (int k = 0; k < SPDS_COMS; k++) begin
				if (stat) check_lvl(com_level[k], com_level[0]);
				else if (k != act && k < cur.n) check_lvl(com_level[k], unsel);
			end
			if (!have_prev) cyc = 0;
			if (have_prev && com_level !== prev_com) begin
				if (stat) begin
					check_bit(pol ^ prev_pol, 1'b1);
				end else begin
					check_cnt(act, (prev_act + 1) % cur.n);
					check_bit(pol ^ prev_pol, act == 0);
				end
				if (n_chg > 0) check_cnt(cyc, cur.period);
				n_chg++;
				cyc = 0;
			end
			cyc++;
			if (cyc == 2) begin
				for (int s = 0; s < cur.segs; s++) begin
					b = cur.mode[7] && mem_nib[s][act];
					check_lvl(seg_level[s], seg_exp(b, pol, cur.half));
					for (int k = 0; k < SPDS_COMS; k++) begin
						if (stat || k < cur.n) check_bit(lit[s][k], b && (stat || k == act));
					end
				end
			end
			prev_com = com_level;
			prev_act = act;
			prev_pol = pol;
			have_prev = 1'b1;
		end
	end
	initial begin
		#4_800_000;
		errors++;
		wrap_up();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sub_clk_pin = 1'b0;
		sub_div = '0;
		chk_on = 1'b0;
		repeat (6) @(posedge core_clk);
		check_mask(SC'(com_level), '0);
		check_mask(SC'(com_oe), '0);
		check_mask(seg_oe, '0);
		check_bit(power_from_bias, 1'b0);
		rst <= 1'b0;
		@(posedge core_clk);
		reg_read(SPDS_MODE_ADDR, rd);
		check_byte(rd, SPDS_MODE_RST);
		reg_read(SPDS_CTRL_ADDR, rd);
		check_byte(rd, SPDS_CTRL_RST);
		reg_read(SPDS_WT_MODE_ADDR, rd);
		check_byte(rd, SPDS_WT_MODE_RST);
		reg_read(SPDS_WT_CSEL_ADDR, rd);
		check_byte(rd, SPDS_WT_CSEL_RST);
		// upper nibble set on write so the read-back proves it is dropped
		for (int s = 0; s < SC; s++) begin
			mem_nib[s] = 4'(s * 5 + 3);
			reg_write(SPDS_MEM_LAST - 16'(s), {4'hA, mem_nib[s]});
		end
		reg_write(16'hFA57, 8'h05);
		reg_read(16'hFA57, rd);
		check_byte(rd, 8'h00);
		reg_read(16'hFA80, rd);
		check_byte(rd, 8'h00);
		for (int s = 0; s < SC; s++) begin
			reg_read(SPDS_MEM_LAST - 16'(s), rd);
			check_byte(rd, {4'h0, mem_nib[s]});
		end
		reg_write(SPDS_WT_MODE_ADDR, 8'h02);
		foreach (rows[i]) begin
			cur = rows[i];
			chk_on = 1'b0;
			reg_write(SPDS_WT_CSEL_ADDR, cur.csel);
			reg_write(SPDS_CTRL_ADDR, cur.ctrl);
			reg_write(SPDS_MODE_ADDR, cur.mode);
			reg_read(SPDS_MODE_ADDR, rd);
			check_byte(rd, cur.mode & SPDS_MODE_WMASK);
			repeat (2) @(posedge core_clk);
			check_mask(seg_oe, (SC'(1) << cur.segs) - 1);
			check_bit(power_from_bias, cur.ctrl[6]);
			chk_on = 1'b1;
			repeat ((2 * cur.n + 1) * cur.period) @(posedge core_clk);
			check_bit(n_chg >= 2 * cur.n, 1'b1);
		end
		chk_on = 1'b0;
		cur = rows[0];
		reg_write(SPDS_WT_CSEL_ADDR, cur.csel);
		reg_write(SPDS_MODE_ADDR, cur.mode);
		reg_write(SPDS_WT_MODE_ADDR, 8'h00);
		repeat (4) @(posedge core_clk);
		chk_on = 1'b1;
		repeat (3 * cur.period) @(posedge core_clk);
		check_cnt(n_chg, 0);
		reg_write(SPDS_WT_MODE_ADDR, 8'h02);
		for (w = 0; w < 2 * cur.period && n_chg == 0; w++) @(posedge core_clk);
		check_bit(n_chg > 0, 1'b1);
		// clock enable low: no level moves and a register write is dropped
		chk_on = 1'b0;
		ce <= 1'b0;
		@(posedge core_clk);
		prev_com = com_level;
		reg_write(SPDS_CTRL_ADDR, 8'h00);
		repeat (2 * cur.period) @(posedge core_clk);
		check_bit(com_level === prev_com, 1'b1);
		ce <= 1'b1;
		reg_read(SPDS_CTRL_ADDR, rd);
		check_byte(rd, cur.ctrl);
		wrap_up();
	end
endmodule: spds_panel_sequencer_bench
